/* File: src/dtp_device.sv */
// converter end: command decode, conversion sequencer and serial trace output
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_device #(
    parameter int unsigned CONV_CYC  = `DTP_CONV_PHASE_CYC,
    parameter bit          ACC_MSB_FIRST = 1'b0,
    parameter bit          IND_CODE_FIRST = 1'b0
) (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    dtp_if.dev              link,
    input  wire logic       start_i,
    input  wire logic       test_mode_i,
    output logic [15:0]     result_o,
    output logic            busy_o
);
    import dtp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rstn_sync_reg;
    logic [1:0] start_sync_reg;
    logic       start_d_reg;
    logic       dev_reset;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rstn_sync_reg  <= 2'b00;
            start_sync_reg <= 2'b00;
            start_d_reg    <= 1'b0;
        end else begin
            rstn_sync_reg  <= {rstn_sync_reg[0], link.reset_n};
            start_sync_reg <= {start_sync_reg[0], start_i};
            start_d_reg    <= start_sync_reg[1];
        end
    end
    assign dev_reset = reset_i | ~rstn_sync_reg[1];

    // ------------------------------------------------------------
    // nonvolatile store and processor registers
    // ------------------------------------------------------------
    logic [15:0] nv_mem [0:7];
    logic [15:0] dsp_reg [0:10];
    logic [7:0]  rom_ptr [0:11];
    logic [7:0]  rom_code [0:11];
    logic        cmd_go;
    logic        cmd_conv;
    logic        cmd_trace;
    logic        cmd_reload;
    logic        conv_start;
    logic        reload_reg;
    logic [3:0]  step_reg;
    dtp_state_e  state_reg;
    logic [16:0] cnt_reg;
    logic [6:0]  nv_bit;
    logic        auto_go;
    assign cmd_go     = link.cmd_valid & rstn_sync_reg[1];
    assign cmd_conv   = cmd_go & link.cmd[3];
    assign cmd_trace  = cmd_conv & ~link.cmd[2];
    assign cmd_reload = cmd_conv & link.cmd[1];
    assign auto_go    = state_reg == DTP_DONE && dsp_reg[0][`DTP_CFG_REPEAT];
    assign conv_start = (state_reg == DTP_IDLE) &&
                        (cmd_conv || (start_sync_reg[1] & ~start_d_reg & ~test_mode_i));
    assign nv_bit     = link.cmd_data[6:0] - 7'h01;

    // microcode trace order; final step is register 0 with code d0
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            rom_ptr[i]  = 8'h00;
            rom_code[i] = 8'h00;
        end
        rom_code[0] = 8'hd8; rom_ptr[0] = 8'h01;
        rom_code[1] = 8'hd9; rom_ptr[1] = 8'h3b;
        rom_code[2] = 8'hd5; rom_ptr[2] = 8'h03;
        rom_code[3] = 8'hd2; rom_ptr[3] = 8'h11;
        rom_code[4] = 8'hd6; rom_ptr[4] = 8'h22;
        rom_code[5] = 8'hd3; rom_ptr[5] = 8'h2e;
        rom_code[6] = 8'hd4; rom_ptr[6] = 8'h38;
        rom_code[7] = 8'hd1; rom_ptr[7] = 8'h47;
        rom_code[8] = 8'hd7; rom_ptr[8] = 8'h56;
        rom_code[9] = `DTP_CODE_OUT; rom_ptr[9] = 8'h65;
        rom_code[10] = `DTP_CODE_REG0; rom_ptr[10] = 8'h66;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 8; i++) nv_mem[i] <= 16'h0000;
        end else if (cmd_go && link.cmd == `DTP_CMD_ERASE) begin
            for (int i = 0; i < 8; i++) nv_mem[i] <= 16'h0000;
        end else if (cmd_go && link.cmd == `DTP_CMD_SETBIT) begin
            if (link.cmd_data[6:0] == 7'h00)
                nv_mem[7][15] <= 1'b1;
            else
                nv_mem[nv_bit[6:4]][nv_bit[3:0]] <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge dev_reset) begin
        if (dev_reset) begin
            for (int i = 0; i < 11; i++) dsp_reg[i] <= 16'h0000;
        end else if (cmd_go && link.cmd == `DTP_CMD_WRREG && link.reg_sel < 4'd8) begin
            dsp_reg[link.reg_sel[2:0]] <= link.cmd_data;
        end else if (state_reg == DTP_CONV && cnt_reg == 17'd0) begin
            if (reload_reg)
                for (int i = 0; i < 8; i++) dsp_reg[i] <= nv_mem[i];
            dsp_reg[8]  <= dsp_reg[8] + 16'h0001;
            dsp_reg[9]  <= dsp_reg[9] + 16'h0003;
            dsp_reg[10] <= dsp_reg[9] + 16'h0003 + dsp_reg[7];
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge dev_reset) begin
        if (dev_reset) begin
            state_reg    <= DTP_IDLE;
            cnt_reg      <= 17'd0;
            step_reg     <= 4'd0;
            reload_reg   <= 1'b0;
        end else begin
            case (state_reg)
                DTP_IDLE: begin
                    if (conv_start) begin
                        state_reg    <= DTP_CONV;
                        cnt_reg      <= 17'(CONV_CYC - 1);
                        reload_reg   <= cmd_conv ? cmd_reload : 1'b1;
                    end
                end
                DTP_CONV: begin
                    if (cnt_reg == 17'd0) begin
                        state_reg <= DTP_GAP;
                        cnt_reg   <= 17'(`DTP_FIRST_GAP_CYC - 9);
                        step_reg  <= 4'd0;
                    end else begin
                        cnt_reg <= cnt_reg - 17'd1;
                    end
                end
                DTP_GAP: begin
                    state_reg <= DTP_FRAME;
                    cnt_reg   <= 17'(`DTP_FRAME_CYC - 1);
                end
                DTP_FRAME: begin
                    if (cnt_reg == 17'd0) begin
                        if (step_reg == 4'd10) begin
                            state_reg <= DTP_DONE;
                        end else begin
                            step_reg <= step_reg + 4'd1;
                            cnt_reg  <= 17'(`DTP_FRAME_CYC - 1);
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 17'd1;
                    end
                end
                DTP_DONE: begin
                    if (auto_go) begin
                        state_reg <= DTP_CONV;
                        cnt_reg   <= 17'(CONV_CYC - 1);
                        reload_reg <= 1'b1;
                    end else begin
                        state_reg <= DTP_IDLE;
                    end
                end
                default: state_reg <= DTP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // trace serialiser
    // ------------------------------------------------------------
    logic        frame_load;
    logic [15:0] acc_val;
    logic [15:0] acc_ord;
    logic [15:0] ind_val;
    logic [3:0]  src_idx;
    logic        ser_data;
    logic        ser_ind;
    assign frame_load = (state_reg == DTP_GAP) || (state_reg == DTP_FRAME && cnt_reg == 17'd0);
    assign src_idx    = (state_reg == DTP_GAP) ? 4'd0 : step_reg + 4'd1;
    always_comb begin
        acc_val = 16'h0000;
        ind_val = 16'h0000;
        if (src_idx < 4'd11) begin
            case (rom_code[src_idx])
                8'hd8:   acc_val = dsp_reg[8];
                8'hd9:   acc_val = dsp_reg[9];
                8'hea:   acc_val = dsp_reg[10];
                default: acc_val = dsp_reg[rom_code[src_idx][2:0]];
            endcase
            ind_val = IND_CODE_FIRST ? {rom_ptr[src_idx], rom_code[src_idx]}
                                     : {rom_code[src_idx], rom_ptr[src_idx]};
        end
        for (int i = 0; i < 16; i++)
            acc_ord[i] = ACC_MSB_FIRST ? acc_val[15 - i] : acc_val[i];
    end

    dtp_shift u_shift (
        .mclk_i  (mclk_i),
        .reset_i (dev_reset),
        .load_i  (frame_load),
        .acc_i   (acc_ord),
        .ind_i   (ind_val),
        .data_o  (ser_data),
        .ind_o   (ser_ind)
    );

    logic pin_data_reg;
    logic pin_ind_reg;
    logic pin_oe_reg;
    always_ff @(posedge mclk_i or posedge dev_reset) begin
        if (dev_reset) begin
            pin_data_reg <= 1'b0;
            pin_ind_reg  <= 1'b0;
            pin_oe_reg   <= 1'b0;
        end else begin
            pin_data_reg <= ser_data;
            pin_ind_reg  <= ser_ind;
            // each start from idle decides afresh (a repeat restart keeps the drive); a silent start must drop a drive left from an earlier trace
            pin_oe_reg   <= conv_start ? (cmd_trace & test_mode_i) : pin_oe_reg;
        end
    end
    assign link.trace_data_pin   = pin_data_reg;
    assign link.trace_ind_dev_o  = pin_ind_reg;
    assign link.trace_ind_dev_oe = pin_oe_reg;
    assign link.trace_data_oe    = pin_oe_reg;

    always_ff @(posedge mclk_i or posedge dev_reset) begin
        if (dev_reset) begin
            result_o <= 16'h0000;
            busy_o   <= 1'b0;
        end else begin
            result_o <= dsp_reg[10];
            busy_o   <= state_reg != DTP_IDLE;
        end
    end
endmodule // dtp_device

/* File: src/dtp_regs.svh */
// constants for the trace test port: offsets, fields, resets, timing
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH
// configuration word fields
`define DTP_CFG_CO_LSB       0
`define DTP_CFG_CO_MSB       1
`define DTP_CFG_CO_SIGN      2
`define DTP_CFG_GAIN_MSB     3
`define DTP_CFG_GAIN_LSB     4
`define DTP_CFG_AMP_EN       7
`define DTP_CFG_TSO_LSB      9
`define DTP_CFG_TSO_MSB      11
`define DTP_CFG_REPEAT       15
`define DTP_CFG_RESET        16'h0000
// nonvolatile bit map
`define DTP_NV_CFG_FIRST     8'h01
`define DTP_NV_CFG_LAST      8'h10
`define DTP_NV_LAST_MSB      8'h00
// commands
`define DTP_CMD_NOOP         4'h0
`define DTP_CMD_WRREG        4'h1
`define DTP_CMD_SETBIT       4'h2
`define DTP_CMD_ERASE        4'h4
`define DTP_CMD_CONV_REG     4'h8
`define DTP_CMD_CONV_NV      4'ha
`define DTP_CMD_CONV_REG_Q   4'hc
`define DTP_CMD_CONV_NV_Q    4'he
// instruction codes
`define DTP_CODE_REG0        8'hd0
`define DTP_CODE_TEMP        8'hd8
`define DTP_CODE_SIG         8'hd9
`define DTP_CODE_OUT         8'hea
// timing in clock cycles
`define DTP_CONV_PHASE_CYC   130585
`define DTP_FRAME_CYC        16
`define DTP_FIRST_GAP_CYC    9
`define DTP_RESET_HOLD_CYC   16
// host register offsets (byte addresses)
`define DTP_OFS_CTRL         32'h00
`define DTP_OFS_STATUS       32'h04
`define DTP_OFS_CAPT0        32'h08
`define DTP_OFS_CAPT_OUT     32'h0c
`define DTP_OFS_CAPT_TEMP    32'h10
`define DTP_OFS_CAPT_SIG     32'h14
`define DTP_OFS_WDATA        32'h18
`endif

/* File: src/dtp_pkg.sv */
// types shared by both ends of the trace test port
package dtp_pkg;
    typedef enum logic [2:0] {
        DTP_IDLE  = 3'b000,
        DTP_CONV  = 3'b001,
        DTP_GAP   = 3'b010,
        DTP_FRAME = 3'b011,
        DTP_DONE  = 3'b100
    } dtp_state_e;
    typedef logic [3:0]  dtp_cmd_t;
    typedef logic [15:0] dtp_word_t;
endpackage

/* File: src/dtp_if.sv */
// link between the converter trace port and the tester
`timescale 1ns/1ps
interface dtp_if;
    logic       reset_n;
    logic [3:0] cmd;
    logic [3:0] reg_sel;
    logic [15:0] cmd_data;
    logic       cmd_valid;
    logic       trace_ind_dev_o;
    logic       trace_ind_dev_oe;
    logic       trace_ind_tst_o;
    logic       trace_ind_tst_oe;
    logic       trace_data_pin;
    logic       trace_data_oe;
    wire        trace_ind = trace_ind_dev_oe ? trace_ind_dev_o :
                            (trace_ind_tst_oe ? trace_ind_tst_o : 1'b1);
    modport dev (input reset_n, cmd, reg_sel, cmd_data, cmd_valid, trace_ind,
                 output trace_ind_dev_o, trace_ind_dev_oe, trace_data_pin, trace_data_oe);
    modport tst (output reset_n, cmd, reg_sel, cmd_data, cmd_valid, trace_ind_tst_o, trace_ind_tst_oe,
                 input trace_ind, trace_data_pin, trace_data_oe);
endinterface

/* File: src/dtp_shift.sv */
// serialiser for one trace frame: accumulator and pointer/code, lsb first
`timescale 1ns/1ps
module dtp_shift (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        load_i,
    input  wire logic [15:0] acc_i,
    input  wire logic [15:0] ind_i,
    output logic             data_o,
    output logic             ind_o
);
    logic [15:0] acc_reg;
    logic [15:0] ind_reg;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg <= 16'h0000;
            ind_reg <= 16'h0000;
        end else if (load_i) begin
            acc_reg <= acc_i;
            ind_reg <= ind_i;
        end else begin
            acc_reg <= {1'b0, acc_reg[15:1]};
            ind_reg <= {1'b0, ind_reg[15:1]};
        end
    end
    assign data_o = acc_reg[0];
    assign ind_o  = ind_reg[0];
endmodule // dtp_shift

/* File: src/dtp_tester.sv */
// tester end: AHB-Lite slave registers, command issue and trace capture
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_tester (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    dtp_if.tst               link,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);
    import dtp_pkg::*;
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic        wr_pend_reg;
    logic [31:0] wa_reg;
    logic [15:0] wdata_reg;
    logic [31:0] ctrl_reg;
    logic        cmd_pulse;
    logic [15:0] capt_reg [0:3];
    logic        frame_done_reg;
    logic        tst_rst_reg;
    logic [4:0]  hold_cnt_reg;
    logic        s_ind_reg;
    logic        s_data_reg;
    logic [4:0]  bit_cnt_reg;
    logic [15:0] acc_sh_reg;
    logic [15:0] ind_sh_reg;
    logic        valid_addr;
    assign valid_addr = hsel_i & htrans_i[1] & hready_i;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_reg <= 1'b0;
            wa_reg      <= 32'h0;
            hrdata_o    <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_pend_reg <= valid_addr & hwrite_i;
            if (valid_addr) wa_reg <= haddr_i;
            if (valid_addr && !hwrite_i) begin
                if (haddr_i == `DTP_OFS_CTRL) hrdata_o <= ctrl_reg;
                else if (haddr_i == `DTP_OFS_STATUS) hrdata_o <= {30'h0, frame_done_reg, link.trace_data_oe};
                else if (haddr_i == `DTP_OFS_CAPT0) hrdata_o <= {16'h0, capt_reg[0]};
                else if (haddr_i == `DTP_OFS_CAPT_OUT) hrdata_o <= {16'h0, capt_reg[1]};
                else if (haddr_i == `DTP_OFS_CAPT_TEMP) hrdata_o <= {16'h0, capt_reg[2]};
                else if (haddr_i == `DTP_OFS_CAPT_SIG) hrdata_o <= {16'h0, capt_reg[3]};
                else if (haddr_i == `DTP_OFS_WDATA) hrdata_o <= {16'h0, wdata_reg};
                else hrdata_o <= 32'h0;
            end
        end
    end
    // ctrl: [3:0] command, [7:4] register select, [8] issue, [9] reset pulse, [10] drive indicator
    assign cmd_pulse = wr_pend_reg && wa_reg == `DTP_OFS_CTRL && hwdata_i[8];
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_reg  <= 32'h0;
            wdata_reg <= 16'h0;
        end else if (wr_pend_reg) begin
            if (wa_reg == `DTP_OFS_CTRL) ctrl_reg <= {21'h0, hwdata_i[10], 2'b00, hwdata_i[7:0]};
            else if (wa_reg == `DTP_OFS_WDATA) wdata_reg <= hwdata_i[15:0];
        end
    end
    // ------------------------------------------------------------
    // link drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            link.cmd_valid <= 1'b0;
            link.cmd       <= `DTP_CMD_NOOP;
            link.reg_sel   <= 4'h0;
            link.cmd_data  <= 16'h0;
            tst_rst_reg    <= 1'b0;
            hold_cnt_reg   <= 5'd0;
        end else begin
            link.cmd_valid <= cmd_pulse;
            if (cmd_pulse) begin
                link.cmd      <= hwdata_i[3:0];
                link.reg_sel  <= hwdata_i[7:4];
                link.cmd_data <= wdata_reg;
            end
            if (wr_pend_reg && wa_reg == `DTP_OFS_CTRL && hwdata_i[9])
                hold_cnt_reg <= 5'(`DTP_RESET_HOLD_CYC);
            else if (hold_cnt_reg != 5'd0)
                hold_cnt_reg <= hold_cnt_reg - 5'd1;
            tst_rst_reg <= (hold_cnt_reg != 5'd0);
        end
    end
    assign link.reset_n = ~tst_rst_reg;
    // release indicator whenever the device drives or ctrl holds a conversion command (bit 3), silent ones included
    assign link.trace_ind_tst_oe = ctrl_reg[10] & ~link.trace_data_oe & ~ctrl_reg[3];
    assign link.trace_ind_tst_o  = 1'b0;
    // ------------------------------------------------------------
    // trace capture on falling edge
    // ------------------------------------------------------------
    always_ff @(negedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ind_reg  <= 1'b0;
            s_data_reg <= 1'b0;
        end else begin
            s_ind_reg  <= link.trace_ind;
            s_data_reg <= link.trace_data_pin;
        end
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt_reg    <= 5'd0;
            acc_sh_reg     <= 16'h0;
            ind_sh_reg     <= 16'h0;
            frame_done_reg <= 1'b0;
            for (int i = 0; i < 4; i++) capt_reg[i] <= 16'h0;
        end else if (!link.trace_data_oe) begin
            bit_cnt_reg <= 5'd0;
        end else begin
            acc_sh_reg <= {s_data_reg, acc_sh_reg[15:1]};
            ind_sh_reg <= {s_ind_reg, ind_sh_reg[15:1]};
            bit_cnt_reg <= (bit_cnt_reg == 5'd15) ? 5'd0 : bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == 5'd15) begin
                if ({s_ind_reg, ind_sh_reg[15:9]} == `DTP_CODE_REG0) begin
                    capt_reg[0]    <= {s_data_reg, acc_sh_reg[15:1]};
                    frame_done_reg <= 1'b1;
                end
                if ({s_ind_reg, ind_sh_reg[15:9]} == `DTP_CODE_OUT) capt_reg[1] <= {s_data_reg, acc_sh_reg[15:1]};
                if ({s_ind_reg, ind_sh_reg[15:9]} == `DTP_CODE_TEMP) capt_reg[2] <= {s_data_reg, acc_sh_reg[15:1]};
                if ({s_ind_reg, ind_sh_reg[15:9]} == `DTP_CODE_SIG) capt_reg[3] <= {s_data_reg, acc_sh_reg[15:1]};
            end
        end
    end
endmodule // dtp_tester

/* File: dv/dtp_link_props.sv */
// assertions on the link between tester end and converter end
`timescale 1ns/1ps
module dtp_link_props #(
    parameter int CONV = 20
) (
    input wire logic       mclk_i,
    input wire logic       reset_i,
    input wire logic       reset_n,
    input wire logic [3:0] cmd,
    input wire logic       cmd_valid,
    input wire logic       trace_ind_dev_oe,
    input wire logic       trace_ind_tst_oe,
    input wire logic       trace_data_oe
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    localparam int MIN_ON = CONV + 175;
    logic [4:0] low_cnt;
    logic [9:0] on_cnt;
    logic       conv;
    logic       quiet;
    assign conv  = cmd_valid && reset_n && !trace_data_oe && (cmd == 4'h8 || cmd == 4'ha);
    assign quiet = cmd_valid && reset_n && !trace_data_oe && (cmd == 4'hc || cmd == 4'he);
    // power-on reset counts as a long enough tester reset
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) low_cnt <= 5'h10;
        else if (reset_n) low_cnt <= 5'h00;
        else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) on_cnt <= 10'h000;
        else if (!trace_data_oe) on_cnt <= 10'h000;
        else if (on_cnt != 10'h3ff) on_cnt <= on_cnt + 10'h001;
    end
    property p_start; conv |-> ##[2:3] (trace_data_oe && trace_ind_dev_oe) [*8]; endproperty
    a_start: assert property (p_start) else $error("trace pins not enabled by start");
    property p_quiet; quiet |-> !trace_data_oe [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("trace pins enabled by silent start");
    property p_pair; trace_data_oe |-> trace_ind_dev_oe; endproperty
    a_pair: assert property (p_pair) else $error("data pin driven without indicator");
    property p_nofight; !(trace_ind_dev_oe && trace_ind_tst_oe); endproperty
    a_nofight: assert property (p_nofight) else $error("both ends drive indicator");
    property p_rst_rel; !reset_n [*4] |-> !trace_ind_dev_oe; endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("indicator driven in reset");
    property p_rst_len; $rose(reset_n) |-> low_cnt >= 5'h10; endproperty
    a_rst_len: assert property (p_rst_len) else $error("tester reset too short");
    property p_src; $rose(trace_data_oe) |-> $past(conv); endproperty
    a_src: assert property (p_src) else $error("trace enabled without start");
    property p_len; $fell(trace_data_oe) && reset_n |-> on_cnt >= MIN_ON; endproperty
    a_len: assert property (p_len) else $error("trace ended too early");
endmodule // dtp_link_props

/* File: dv/dtp_trace_test_port_bench.sv */
// self-checking bench for the tester and converter ends
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_trace_test_port_bench;
    // tester's free-running bit count meets frame edges only when CONV is 14 modulo 16
    localparam int CONV = 30;
    logic        mclk_i, reset_i, start_i, test_mode_i, busy_o, hwrite, hready, hresp;
    logic [1:0]  htrans;
    logic [15:0] result_o;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          n_fail = 0;
    int          num_checks = 0;
    dtp_if link();
    dtp_device #(.CONV_CYC(CONV)) u_dtp_device (.mclk_i(mclk_i), .reset_i(reset_i), .link(link),
        .start_i(start_i), .test_mode_i(test_mode_i), .result_o(result_o), .busy_o(busy_o));
    dtp_tester u_dtp_tester (.mclk_i(mclk_i), .reset_i(reset_i), .link(link), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
    dtp_link_props #(.CONV(CONV)) u_dtp_link_props (.mclk_i(mclk_i), .reset_i(reset_i),
        .reset_n(link.reset_n), .cmd(link.cmd), .cmd_valid(link.cmd_valid),
        .trace_ind_dev_oe(link.trace_ind_dev_oe), .trace_ind_tst_oe(link.trace_ind_tst_oe),
        .trace_data_oe(link.trace_data_oe));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // bus access, checks and waits
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k = 0;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge mclk_i); k++; end while (hready !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge mclk_i); k++; end while (hready !== 1'b1 && k < 50);
        q = hrdata;
        if (k >= 50) begin n_fail++; summarize(); end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wait_busy(input logic lvl);
        int k = 0;
        while (busy_o !== lvl) begin
            @(posedge mclk_i);
            k++;
            if (k > 1000) begin n_fail++; summarize(); end
        end
    endtask
    // command code 0 here means a start by the start pin
    task automatic run(input logic [3:0] c, input logic exp_oe);
        if (c == 4'h0) start_i <= 1'b1;
        else ahb(1'b1, `DTP_OFS_CTRL, {23'h0, 1'b1, 4'h0, c});
        wait_busy(1'b1);
        repeat (40) @(posedge mclk_i);
        ahb(1'b0, `DTP_OFS_STATUS, 32'h0);
        chk("trace enable", {31'h0, exp_oe}, {31'h0, q[0]});
        wait_busy(1'b0);
        start_i <= 1'b0;
    endtask
    initial begin
        reset_i = 1'b1; start_i = 1'b0; test_mode_i = 1'b1;
        htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        rdchk("status at reset", `DTP_OFS_STATUS, 32'h0);
        rdchk("unmapped read", 32'h40, 32'h0);
        ahb(1'b1, `DTP_OFS_WDATA, 32'h0e97);
        ahb(1'b1, `DTP_OFS_CTRL, 32'h101);
        repeat (4) @(posedge mclk_i);
        run(4'h8, 1'b1);
        rdchk("reg0 capture", `DTP_OFS_CAPT0, 32'h0e97);
        rdchk("temp capture", `DTP_OFS_CAPT_TEMP, 32'h1);
        rdchk("signal capture", `DTP_OFS_CAPT_SIG, 32'h3);
        rdchk("output capture", `DTP_OFS_CAPT_OUT, 32'h3);
        chk("result", 32'h3, {16'h0, result_o});
        ahb(1'b0, `DTP_OFS_STATUS, 32'h0);
        chk("end marker", 32'h1, {31'h0, q[1]});
        ahb(1'b1, `DTP_OFS_CTRL, 32'h200);
        repeat (40) @(posedge mclk_i);
        run(4'h8, 1'b1);
        rdchk("reg0 after reset", `DTP_OFS_CAPT0, 32'h0);
        rdchk("temp after reset", `DTP_OFS_CAPT_TEMP, 32'h1);
        run(4'hc, 1'b0);
        run(4'ha, 1'b1);
        run(4'he, 1'b0);
        test_mode_i <= 1'b0;
        run(4'h0, 1'b0);
        summarize();
    end
endmodule // dtp_trace_test_port_bench
